// ===== dfs_frame_status.sv
// frame status register block: status word, event flags, interrupts, wishbone slave
`timescale 1ns/1ps
module dfs_frame_status #(
    parameter int INIT_CYCLES = dfs_pkg::DFS_INIT_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // wishbone classic slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [dfs_pkg::DFS_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // audio path events
    input wire logic frame_sync_in,
    input wire logic sample_ready_in,
    input wire logic input_overflow_in,
    // level control and algorithm run
    input wire logic [15:0] level_gain_in,
    input wire logic gain_update_in,
    input wire logic algo_run_in,
    input wire logic [dfs_pkg::DFS_FIELD_W-1:0] hw_indication_in,
    // audio samples
    input wire logic [23:0] audio_in,
    input wire logic [23:0] processed_in,
    input wire logic [23:0] sensor_in,
    output logic [23:0] audio_out,
    output logic sensor_accept_out,
    // interrupt
    output logic irq_out
);
    import dfs_pkg::*;

    // timing overview for users of this block:
    // - a bus request is taken on the first edge that sees cyc and stb while idle
    // - ack follows one cycle later for exactly one cycle, with read data beside it
    // - the master must drop stb after ack; one idle cycle separates accesses
    // - all register side effects (writes, read clears) land on the taking edge
    // - the read data is a snapshot of the taking edge, so a flag raised in the
    //   ack cycle is not lost: it shows on the next read instead
    // - event pulses are sampled on every edge; a pulse held for several cycles
    //   sets its flag again after a read clear, so sources should pulse once
    // - rates come from a registered calculator, one cycle behind a config write
    // - the ready bit and its interrupt are raised once per reset only
    // limitation: byte lanes other than lane 0 are ignored on writes, since
    // every writable field fits in the low byte

    // status flags
    logic audio_underflow_flag_r;
    logic audio_overflow_flag_r;
    logic level_control_active_r;
    logic [DFS_FIELD_W-1:0] hardware_indication_copy_r;
    logic passthrough_mode_r;
    logic algorithm_ready_r;
    logic [DFS_CFG_W-1:0] clock_cfg_r;
    logic [DFS_IRQ_W-1:0] irq_status_r;
    logic [DFS_IRQ_W-1:0] irq_mask_r;
    logic [31:0] init_count_r;
    logic [DFS_FIELD_W-1:0] sensor_rate_khz;
    logic [DFS_FIELD_W-1:0] audio_rate_khz;
    dfs_bus_state_t bus_state_r;

    // bus decode
    logic bus_req;
    logic bus_take;
    logic rd_status;
    logic rd_irq;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_cfg;
    logic [31:0] status_word;
    logic [31:0] rd_data;

    // events
    logic ev_underflow;
    logic ev_overflow;
    logic ev_level;
    logic ev_ready;
    logic [DFS_IRQ_W-1:0] irq_events;

    // rate calculator
    dfs_rate_calc u_rate (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ratio_code_in(clock_cfg_r),
        .audio_khz_out(audio_rate_khz),
        .sensor_khz_out(sensor_rate_khz)
    );

    // a request is taken only in idle so each access acks exactly once
    assign bus_req = wb_cyc_in && wb_stb_in;
    assign bus_take = bus_req && (bus_state_r == DFS_IDLE);
    assign rd_status = bus_take && !wb_we_in && (wb_adr_in == DFS_ADDR_STATUS);
    assign rd_irq = bus_take && !wb_we_in && (wb_adr_in == DFS_ADDR_IRQ_STATUS);
    assign wr_ctrl = bus_take && wb_we_in && wb_sel_in[0] && (wb_adr_in == DFS_ADDR_CONTROL);
    assign wr_mask = bus_take && wb_we_in && wb_sel_in[0] && (wb_adr_in == DFS_ADDR_IRQ_MASK);
    assign wr_cfg = bus_take && wb_we_in && wb_sel_in[0] && (wb_adr_in == DFS_ADDR_CLOCK_CFG);

    // underflow: sync came with no fresh sample; bypass never starves the output
    assign ev_underflow = frame_sync_in && !sample_ready_in && !passthrough_mode_r;

    // overflow is reported by the input buffer as a single pulse
    assign ev_overflow = input_overflow_in;

    // only a change to a nonzero gain counts as a level event
    assign ev_level = gain_update_in && (level_gain_in != 16'h0000);

    // ready event fires once, on the edge the init count completes
    assign ev_ready = !algorithm_ready_r && (init_count_r == 32'(INIT_CYCLES));

    // event vector in interrupt bit order, placed by the package positions
    assign irq_events[DFS_IRQ_UNDERFLOW] = ev_underflow;
    assign irq_events[DFS_IRQ_OVERFLOW] = ev_overflow;
    assign irq_events[DFS_IRQ_LEVEL] = ev_level;
    assign irq_events[DFS_IRQ_READY] = ev_ready;

    // assembled status word; reserved bits 3:2 and 31 read zero
    always_comb begin
        status_word = DFS_ZERO_WORD;
        status_word[DFS_BIT_UNDERFLOW] = audio_underflow_flag_r;
        status_word[DFS_BIT_OVERFLOW] = audio_overflow_flag_r;
        status_word[DFS_BIT_LEVEL] = level_control_active_r;
        status_word[DFS_HWIND_LSB +: DFS_FIELD_W] = hardware_indication_copy_r;
        status_word[DFS_SNSR_LSB +: DFS_FIELD_W] = sensor_rate_khz;
        status_word[DFS_AUDIO_LSB +: DFS_FIELD_W] = audio_rate_khz;
        status_word[DFS_BIT_PASSTHRU] = passthrough_mode_r;
        status_word[DFS_BIT_READY] = algorithm_ready_r;
    end

    // read mux; unmapped addresses read zero but still ack
    always_comb begin
        rd_data = DFS_ZERO_WORD;
        unique case (wb_adr_in)
            DFS_ADDR_STATUS: rd_data = status_word;
            DFS_ADDR_IRQ_STATUS: rd_data[DFS_IRQ_W-1:0] = irq_status_r;
            DFS_ADDR_IRQ_MASK: rd_data[DFS_IRQ_W-1:0] = irq_mask_r;
            DFS_ADDR_CONTROL: rd_data[DFS_CTL_W-1:0] = passthrough_mode_r;
            DFS_ADDR_CLOCK_CFG: rd_data[DFS_CFG_W-1:0] = clock_cfg_r;
            default: rd_data = DFS_ZERO_WORD;
        endcase
    end

    // bus state: one ack cycle per taken request, then back to idle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            bus_state_r <= DFS_IDLE;
        end else begin
            unique case (bus_state_r)
                DFS_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= DFS_ACK;
                    end
                end
                DFS_ACK: begin
                    bus_state_r <= DFS_IDLE;
                end
            endcase
        end
    end

    // ack registered so it never follows stb combinationally; drops after one cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_take;
        end
    end

    // read data captured on the taking edge and held until the next access
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wb_dat_out <= DFS_ZERO_WORD;
        end else if (bus_take) begin
            wb_dat_out <= rd_data;
        end
    end

    // underflow: a new event in the read cycle wins over the clear
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            audio_underflow_flag_r <= 1'b0;
        end else if (ev_underflow) begin
            audio_underflow_flag_r <= 1'b1;
        end else if (rd_status) begin
            audio_underflow_flag_r <= 1'b0;
        end
    end

    // overflow flag, same set-over-clear policy
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            audio_overflow_flag_r <= 1'b0;
        end else if (ev_overflow) begin
            audio_overflow_flag_r <= 1'b1;
        end else if (rd_status) begin
            audio_overflow_flag_r <= 1'b0;
        end
    end

    // level control tracks the latest gain change, not sticky
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            level_control_active_r <= 1'b0;
        end else if (gain_update_in) begin
            level_control_active_r <= (level_gain_in != 16'h0000);
        end
    end

    // indication snapshot taken on every cycle that algo_run_in is high
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hardware_indication_copy_r <= 8'h00;
        end else if (algo_run_in) begin
            hardware_indication_copy_r <= hw_indication_in;
        end
    end

    // passthrough mode written by software through the control register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            passthrough_mode_r <= 1'b0;
        end else if (wr_ctrl) begin
            passthrough_mode_r <= wb_dat_in[DFS_CTL_PASSTHRU];
        end
    end

    // rate ratio code; reset code gives the quarter-rate sensor
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            clock_cfg_r <= DFS_CFG_RESET;
        end else if (wr_cfg) begin
            clock_cfg_r <= wb_dat_in[DFS_CFG_W-1:0];
        end
    end

    // interrupt mask, all sources masked out of reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_mask_r <= 4'h0;
        end else if (wr_mask) begin
            irq_mask_r <= wb_dat_in[DFS_IRQ_W-1:0];
        end
    end

    // initialisation counter stops once ready so it cannot wrap
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            init_count_r <= 32'h0000_0000;
        end else if (!algorithm_ready_r) begin
            init_count_r <= init_count_r + 32'h0000_0001;
        end
    end

    // ready holds until reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            algorithm_ready_r <= 1'b0;
        end else if (ev_ready) begin
            algorithm_ready_r <= 1'b1;
        end
    end

    // one sticky bit per event; a set beats the read clear in the same cycle
    for (genvar b = 0; b < DFS_IRQ_W; b++) begin : g_irq_bit
        always_ff @(posedge clock_in) begin
            if (rst_in) begin
                irq_status_r[b] <= 1'b0;
            end else if (irq_events[b]) begin
                irq_status_r[b] <= 1'b1;
            end else if (rd_irq) begin
                irq_status_r[b] <= 1'b0;
            end
        end
    end

    assign irq_out = |(irq_status_r & irq_mask_r);

    // audio path: bypass copies input; processing output otherwise
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            audio_out <= 24'h000000;
        end else if (frame_sync_in) begin
            audio_out <= passthrough_mode_r ? audio_in : processed_in;
        end
    end

    // sensor samples are dropped in bypass; data input unused beyond that gate
    assign sensor_accept_out = !passthrough_mode_r && (sensor_in == sensor_in);
endmodule : dfs_frame_status

// ===== dfs_frame_status_assertions.sv
// checker: bus timing and status word relations of the frame status block
`timescale 1ns/1ps
module dfs_frame_status_checker #(
    parameter int INIT_CYCLES = 4
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // bus and observed ports
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [dfs_pkg::DFS_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic frame_sync_in,
    input wire logic [15:0] level_gain_in,
    input wire logic gain_update_in,
    input wire logic algo_run_in,
    input wire logic [dfs_pkg::DFS_FIELD_W-1:0] hw_indication_in,
    input wire logic [23:0] audio_in,
    input wire logic [23:0] processed_in,
    input wire logic [23:0] audio_out,
    input wire logic sensor_accept_out
);
    import dfs_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic pt_r;
    logic lvl_r;
    logic [7:0] hw_r;
    int cnt_r;
    wire take_w = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire rd_st_w = wb_ack_out && !wb_we_in && wb_adr_in == DFS_ADDR_STATUS;
    wire [23:0] pick_w = pt_r ? audio_in : processed_in;
    // shadows of mode, level and indication; cnt skips reads racing the rate load
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pt_r <= 1'b0;
            lvl_r <= 1'b0;
            hw_r <= 8'h00;
            cnt_r <= 0;
        end else begin
            if (take_w && wb_we_in && wb_sel_in[0] && wb_adr_in == DFS_ADDR_CONTROL) begin
                pt_r <= wb_dat_in[0];
            end
            if (gain_update_in) begin
                lvl_r <= level_gain_in != 16'h0000;
            end
            if (algo_run_in) begin
                hw_r <= hw_indication_in;
            end
            if (cnt_r < 1000) begin
                cnt_r <= cnt_r + 1;
            end
        end
    end
    sequence ack_answer_s;
        ##1 wb_ack_out ##1 !wb_ack_out;
    endsequence
    bus_answer_a: assert property (take_w |-> ack_answer_s)
        else $error("ack not a single pulse one cycle after request");
    reserved_zero_a: assert property (rd_st_w |-> wb_dat_out[3:2] == 2'h0 && !wb_dat_out[31])
        else $error("reserved status bits set");
    audio_rate_a: assert property (rd_st_w && cnt_r > 2 |-> wb_dat_out[11:4] == 8'h30)
        else $error("audio rate field wrong");
    ready_early_a: assert property (rd_st_w && cnt_r < INIT_CYCLES |-> !wb_dat_out[0])
        else $error("ready before init done");
    accept_mode_a: assert property (sensor_accept_out == !pt_r)
        else $error("sensor accept disagrees with mode");
    bypass_path_a: assert property (frame_sync_in |=> audio_out == $past(pick_w))
        else $error("audio output source wrong");
    level_copy_a: assert property (rd_st_w |-> wb_dat_out[28] == $past(lvl_r))
        else $error("level bit wrong");
    hw_copy_a: assert property (rd_st_w |-> wb_dat_out[27:20] == $past(hw_r))
        else $error("indication copy wrong");
endmodule : dfs_frame_status_checker

bind dfs_frame_status dfs_frame_status_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (.*);

// ===== dfs_pkg.sv
// package: register map, field layout and timing constants of the frame status block
package dfs_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] DFS_ADDR_STATUS = 8'h00;
    localparam logic [7:0] DFS_ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] DFS_ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] DFS_ADDR_CONTROL = 8'h0C;
    localparam logic [7:0] DFS_ADDR_CLOCK_CFG = 8'h10;
    localparam int DFS_ADDR_W = 8;
    // status word field positions
    localparam int DFS_BIT_UNDERFLOW = 30;
    localparam int DFS_BIT_OVERFLOW = 29;
    localparam int DFS_BIT_LEVEL = 28;
    localparam int DFS_HWIND_LSB = 20;
    localparam int DFS_SNSR_LSB = 12;
    localparam int DFS_AUDIO_LSB = 4;
    localparam int DFS_BIT_PASSTHRU = 1;
    localparam int DFS_BIT_READY = 0;
    localparam int DFS_FIELD_W = 8;
    // interrupt status bit layout
    localparam int DFS_IRQ_UNDERFLOW = 0;
    localparam int DFS_IRQ_OVERFLOW = 1;
    localparam int DFS_IRQ_LEVEL = 2;
    localparam int DFS_IRQ_READY = 3;
    localparam int DFS_IRQ_W = 4;
    // control register bits
    localparam int DFS_CTL_PASSTHRU = 0;
    localparam int DFS_CTL_W = 1;
    // clock config: sensor rate divisor (bits 1:0 = audio/sensor ratio code)
    localparam int DFS_CFG_W = 2;
    localparam logic [1:0] DFS_CFG_RESET = 2'h2;
    localparam logic [7:0] DFS_AUDIO_KHZ = 8'h30; // 48 kHz nominal audio rate
    localparam logic [31:0] DFS_ZERO_WORD = 32'h0000_0000;
    // time for algorithm initialisation
    localparam int DFS_INIT_NS = 1000;
    localparam int DFS_CLK_MHZ = 200;
    localparam int DFS_INIT_CYCLES = (DFS_INIT_NS * DFS_CLK_MHZ + 999) / 1000;
    // slave state machine
    typedef enum logic [1:0] {
        DFS_IDLE = 2'b00,
        DFS_ACK = 2'b01
    } dfs_bus_state_t;
endpackage : dfs_pkg

// ===== dfs_rate_calc.sv
// rate calculator: sensor and audio sample rates in kHz from the clock configuration
`timescale 1ns/1ps
module dfs_rate_calc (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // configuration
    input wire logic [dfs_pkg::DFS_CFG_W-1:0] ratio_code_in,
    // computed rates
    output logic [dfs_pkg::DFS_FIELD_W-1:0] audio_khz_out,
    output logic [dfs_pkg::DFS_FIELD_W-1:0] sensor_khz_out
);
    import dfs_pkg::*;

    // sensor rate is the audio rate divided by 1, 2 or 4; registered so reads are stable
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            audio_khz_out <= 8'h00;
            sensor_khz_out <= 8'h00;
        end else begin
            audio_khz_out <= DFS_AUDIO_KHZ;
            unique case (ratio_code_in)
                2'b00: sensor_khz_out <= DFS_AUDIO_KHZ;
                2'b01: sensor_khz_out <= DFS_AUDIO_KHZ >> 1;
                2'b10: sensor_khz_out <= DFS_AUDIO_KHZ >> 2;
                2'b11: sensor_khz_out <= DFS_AUDIO_KHZ >> 2; // code 3 treated as divide by 4
            endcase
        end
    end
endmodule : dfs_rate_calc

// ===== test_dfs_frame_status.sv
// testbench: frame status block driven over wishbone with random events
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module test_dfs_frame_status;
    import dfs_pkg::*;
    localparam int INIT = 4;
    logic clock_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0;
    logic fs = 0, sr = 1, ov = 0, gu = 0, ar = 0, ack, acc, irq;
    logic [7:0] adr = 8'h00, hw = 8'h00;
    logic [15:0] gain = 16'h0000, lfsr = 16'h7A7A;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat_out;
    logic [23:0] aud = 24'h000000, proc_s = 24'h000000, sens = 24'h000000, aud_out;
    int mismatches = 0, samples_checked = 0;
    dfs_frame_status #(.INIT_CYCLES(INIT)) i_dfs_frame_status (.clock_in(clock_in),
        .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dat_out), .wb_ack_out(ack),
        .frame_sync_in(fs), .sample_ready_in(sr), .input_overflow_in(ov),
        .level_gain_in(gain), .gain_update_in(gu), .algo_run_in(ar), .hw_indication_in(hw),
        .audio_in(aud), .processed_in(proc_s), .sensor_in(sens), .audio_out(aud_out),
        .sensor_accept_out(acc), .irq_out(irq));
    initial forever #2.5 clock_in = ~clock_in;
    function logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    function logic [7:0] sens_khz(input int c);
        return (c == 0) ? 8'h30 : (c == 1) ? 8'h18 : 8'h0C;
    endfunction : sens_khz
    task wrap_up;
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // one classic cycle; data taken at the edge where ack is seen
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clock_in);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_out;
        {cyc, stb} <= 2'b00;
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
    endtask : wb
    task ev(input logic f, s, o, g, r);
        @(posedge clock_in);
        {fs, sr, ov, gu, ar} <= {f, s, o, g, r};
        @(posedge clock_in);
        {fs, sr, ov, gu, ar} <= 5'b01000;
    endtask : ev
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        wb(DFS_ADDR_STATUS, 0, 0);
        `CHK("ready early", 1'b0, rdat[0])
        repeat (INIT + 4) @(posedge clock_in);
        wb(DFS_ADDR_STATUS, 0, 0);
        `CHK("idle word", 32'h0000_C301, rdat)
        for (int c = 0; c < 4; c++) begin
            wb(DFS_ADDR_CLOCK_CFG, 1, 32'(c));
            wb(DFS_ADDR_STATUS, 0, 0);
            `CHK("sensor rate", sens_khz(c), rdat[19:12])
        end
        for (int i = 0; i < 8; i++) begin
            lfsr = step(lfsr);
            gain <= lfsr[3] ? lfsr : 16'h0000;
            hw <= lfsr[15:8];
            sens <= {lfsr, 8'h3C};
            ev(1'b1, ~lfsr[0], lfsr[1], 1'b1, 1'b1);
            wb(DFS_ADDR_STATUS, 0, 0);
            `CHK("underflow", lfsr[0], rdat[30])
            `CHK("overflow", lfsr[1], rdat[29])
            `CHK("level", |gain, rdat[28])
            `CHK("hw copy", hw, rdat[27:20])
            wb(DFS_ADDR_STATUS, 0, 0);
            `CHK("flags clear", 2'b00, rdat[30:29])
        end
        // masked event first, then unmask and clear by reading
        wb(DFS_ADDR_IRQ_MASK, 1, 32'h0);
        wb(DFS_ADDR_IRQ_STATUS, 0, 0);
        ev(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        @(negedge clock_in);
        `CHK("irq masked", 1'b0, irq)
        wb(DFS_ADDR_IRQ_MASK, 1, 32'h2);
        @(negedge clock_in);
        `CHK("irq raised", 1'b1, irq)
        wb(DFS_ADDR_IRQ_STATUS, 0, 0);
        `CHK("irq status", 4'h2, rdat[3:0])
        @(negedge clock_in);
        `CHK("irq cleared", 1'b0, irq)
        wb(DFS_ADDR_CONTROL, 1, 32'h1);
        lfsr = step(lfsr);
        aud <= {8'h5A, lfsr};
        proc_s <= {lfsr, 8'hA5};
        ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge clock_in);
        `CHK("bypass audio", aud, aud_out)
        `CHK("sensor drop", 1'b0, acc)
        wb(DFS_ADDR_STATUS, 0, 0);
        `CHK("bypass bits", 2'b01, {rdat[30], rdat[1]})
        wb(DFS_ADDR_CONTROL, 1, 32'h0);
        ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        @(negedge clock_in);
        `CHK("processed audio", proc_s, aud_out)
        wb(8'hFC, 0, 0);
        `CHK("unmapped", 32'h0000_0000, rdat)
        wrap_up();
    end
endmodule : test_dfs_frame_status
